/* File: rtl/scbc_loader.sv */
/*
 * Strap loader: captures board straps under reset and drives static clock and
 * bus configuration, a pci clock enable and an isa clock select.
 * Assumes straps are stable pull resistors, synchronous to clock, and that
 * rst is held at least one clock edge.
 */
// Overview of operation
// - memory clock mode is async when the sync strap is 0 and sync when it is 1.
// - the core runs at one times host clock for strap 0 and two times for strap 1.
// - the expansion interface is isa for bus strap 0 and the 16-bit local bus for 1.
// - in local bus mode dma is disabled and no dma request/acknowledge muxing is used.
// - the pci clock is one half, one third or one quarter of the cpu bus clock.
// - the isa clock comes from the 14.318 MHz oscillator or from the pci clock.
`timescale 1ns/1ns
module scbc_loader (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       mem_host_sync_strap,
    input  wire logic       core_ratio_strap,
    input  wire logic       bus_select_strap,
    input  wire logic [1:0] pci_ratio_strap,
    input  wire logic       isa_src_strap,
    output logic            mem_sync,
    output logic            core_ratio_double,
    output logic            core_ratio_single,
    output logic            bus_local,
    output logic            dma_enable,
    output logic            dma_mux_enable,
    output logic [1:0]      pci_ratio_sel,
    output logic            pci_clk_tick,
    output logic            isa_clk_from_pci,
    output logic            cfg_valid
);
    import scbc_pkg::*;

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    // the spare ratio code 3 folds onto divide by two, so the divider
    // never sees a code that it cannot decode
    function automatic logic [1:0] fold_ratio(input logic [1:0] code);
        if (code == 2'h3) begin
            fold_ratio = SCBC_DIV_2;
        end else begin
            fold_ratio = code;
        end
    endfunction : fold_ratio

    // ----------------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------------
    scbc_state_t state_reg;
    scbc_state_t state_next;
    logic        mem_reg,   mem_next;
    logic        core_reg,  core_next;
    logic        bus_reg,   bus_next;
    logic [1:0]  ratio_reg, ratio_next;
    logic        isa_reg,   isa_next;

    // reset loads the straps straight into their registers, each reset cycle overwriting the last,
    // and the sample state loads them once more so the value on the first edge after release sticks
    always_comb begin
        state_next = SCBC_HOLD;
        mem_next   = mem_reg;
        core_next  = core_reg;
        bus_next   = bus_reg;
        ratio_next = ratio_reg;
        isa_next   = isa_reg;
        if (state_reg == SCBC_SAMPLE) begin
            mem_next   = mem_host_sync_strap;
            core_next  = core_ratio_strap;
            bus_next   = bus_select_strap;
            ratio_next = fold_ratio(pci_ratio_strap);
            isa_next   = isa_src_strap;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= SCBC_SAMPLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // strap registers are not reset: sampling happens while rst is high
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_reg   <= mem_host_sync_strap;
            core_reg  <= core_ratio_strap;
            bus_reg   <= bus_select_strap;
            ratio_reg <= fold_ratio(pci_ratio_strap);
            isa_reg   <= isa_src_strap;
        end else begin
            mem_reg   <= mem_next;
            core_reg  <= core_next;
            bus_reg   <= bus_next;
            ratio_reg <= ratio_next;
            isa_reg   <= isa_next;
        end
    end

    // ----------------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------------
    logic out_mem_reg, out_core_reg, out_single_reg, out_bus_reg;
    logic out_dma_reg, out_mux_reg, out_isa_reg, out_valid_reg;
    logic [1:0] out_ratio_reg;
    logic out_mem_next, out_core_next, out_single_next, out_bus_next;
    logic out_dma_next, out_mux_next, out_isa_next, out_valid_next;
    logic [1:0] out_ratio_next;

    // outputs stay at safe defaults until the straps are latched
    always_comb begin
        out_valid_next  = (state_reg == SCBC_HOLD);
        out_mem_next    = out_valid_next ? mem_reg : CFG_RESET;
        out_core_next   = out_valid_next ? core_reg : CFG_RESET;
        out_single_next = (out_core_next == CORE_RATIO_SINGLE);
        out_bus_next    = out_valid_next ? bus_reg : CFG_RESET;
        out_dma_next    = out_valid_next && (bus_reg == BUS_ISA);
        out_mux_next    = out_valid_next && (bus_reg == BUS_ISA);
        out_ratio_next  = out_valid_next ? ratio_reg : DIV_SEL_RESET;
        out_isa_next    = out_valid_next ? isa_reg : ISA_SRC_OSC;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            out_valid_reg  <= CFG_RESET;
            out_mem_reg    <= CFG_RESET;
            out_core_reg   <= CFG_RESET;
            out_single_reg <= 1'h1;
            out_bus_reg    <= CFG_RESET;
            out_dma_reg    <= CFG_RESET;
            out_mux_reg    <= CFG_RESET;
            out_ratio_reg  <= DIV_SEL_RESET;
            out_isa_reg    <= ISA_SRC_OSC;
        end else begin
            out_valid_reg  <= out_valid_next;
            out_mem_reg    <= out_mem_next;
            out_core_reg   <= out_core_next;
            out_single_reg <= out_single_next;
            out_bus_reg    <= out_bus_next;
            out_dma_reg    <= out_dma_next;
            out_mux_reg    <= out_mux_next;
            out_ratio_reg  <= out_ratio_next;
            out_isa_reg    <= out_isa_next;
        end
    end

    // ----------------------------------------------------------------------
    // pci clock divider
    // ----------------------------------------------------------------------
    logic tick_w;

    scbc_clkdiv u_scbc_clkdiv (
        .clock     (clock),
        .rst       (rst),
        .ratio_sel (out_ratio_reg),
        .tick      (tick_w)
    );

    assign mem_sync          = out_mem_reg;
    assign core_ratio_double = out_core_reg;
    assign core_ratio_single = out_single_reg;
    assign bus_local         = out_bus_reg;
    assign dma_enable        = out_dma_reg;
    assign dma_mux_enable    = out_mux_reg;
    assign pci_ratio_sel     = out_ratio_reg;
    assign pci_clk_tick      = tick_w;
    assign isa_clk_from_pci  = out_isa_reg;
    assign cfg_valid         = out_valid_reg;

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_MEM_FOLLOWS_STRAP: assert property (cfg_valid |-> mem_sync == mem_reg)
        else $error("memory sync mode differs from latched strap");
    AST_CORE_RATIO: assert property (cfg_valid |-> core_ratio_double != core_ratio_single)
        else $error("core ratio outputs not exclusive");
    AST_BUS_SEL: assert property (cfg_valid |-> bus_local == bus_reg)
        else $error("bus select differs from latched strap");
    AST_NO_DMA_LOCAL: assert property (bus_local |-> !dma_enable && !dma_mux_enable)
        else $error("dma active in local bus mode");

    // a tick followed by the gap that each ratio asks for
    sequence s_tick_gap2;
        pci_clk_tick ##1 !pci_clk_tick ##1 pci_clk_tick;
    endsequence
    sequence s_tick_gap3;
        pci_clk_tick ##1 (!pci_clk_tick) [*2] ##1 pci_clk_tick;
    endsequence
    sequence s_tick_gap4;
        pci_clk_tick ##1 (!pci_clk_tick) [*3] ##1 pci_clk_tick;
    endsequence
    // two quiet edges while the outputs leave their defaults, then a steady valid
    sequence s_load_latency;
        !cfg_valid ##1 !cfg_valid ##1 cfg_valid [*3];
    endsequence

    // the period is only judged once the new ratio has had a few ticks to settle
    AST_PCI_HALF: assert property (cfg_valid && $past(cfg_valid, 4) && pci_ratio_sel == SCBC_DIV_2
        && pci_clk_tick |-> s_tick_gap2)
        else $error("pci tick not every two clocks");
    AST_PCI_THIRD: assert property (cfg_valid && $past(cfg_valid, 8) && pci_ratio_sel == SCBC_DIV_3
        && pci_clk_tick |-> s_tick_gap3)
        else $error("pci tick not every three clocks");
    AST_PCI_QUARTER: assert property (cfg_valid && $past(cfg_valid, 8) && pci_ratio_sel == SCBC_DIV_4
        && pci_clk_tick |-> s_tick_gap4)
        else $error("pci tick not every four clocks");
    AST_ISA_SRC: assert property (cfg_valid |-> isa_clk_from_pci == isa_reg)
        else $error("isa clock source differs from latched strap");
    // straps seen on the first edge after release are what the outputs must show
    AST_STRAP_AT_RELEASE: assert property ($rose(cfg_valid) |-> mem_sync == $past(mem_host_sync_strap, 2)
        && core_ratio_double == $past(core_ratio_strap, 2) && bus_local == $past(bus_select_strap, 2)
        && isa_clk_from_pci == $past(isa_src_strap, 2))
        else $error("configuration does not match straps seen at release");
    AST_HOLD_STABLE: assert property (cfg_valid ##1 cfg_valid |->
        $stable({mem_sync, bus_local, core_ratio_double, pci_ratio_sel, isa_clk_from_pci}))
        else $error("configuration changed outside reset");
    AST_VALID_TIME: assert property ($fell(rst) |-> s_load_latency)
        else $error("configuration not valid two clocks after reset");

endmodule : scbc_loader

/* File: rtl/scbc_pkg.sv */
/*
 * Package for the strap clock and bus configuration loader: encodings, divider
 * ratios and reset values shared by the loader and its clock divider.
 * Assumes a single 100 MHz host clock domain.
 */
package scbc_pkg;

    // ----------------------------------------------------------------------
    // strap encodings
    // ----------------------------------------------------------------------
    localparam logic       MEM_ASYNC          = 1'h0;
    localparam logic       MEM_SYNC           = 1'h1;
    localparam logic       CORE_RATIO_SINGLE  = 1'h0;
    localparam logic       CORE_RATIO_DOUBLE  = 1'h1;
    localparam logic       BUS_ISA            = 1'h0;
    localparam logic       BUS_LOCAL          = 1'h1;
    localparam logic       ISA_SRC_OSC        = 1'h0;
    localparam logic       ISA_SRC_PCI        = 1'h1;

    // ----------------------------------------------------------------------
    // pci clock ratio select
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCBC_DIV_2 = 2'h0,
        SCBC_DIV_3 = 2'h1,
        SCBC_DIV_4 = 2'h2
    } scbc_div_t;

    localparam logic [2:0] DIV_COUNT_2        = 3'h2;
    localparam logic [2:0] DIV_COUNT_3        = 3'h3;
    localparam logic [2:0] DIV_COUNT_4        = 3'h4;
    localparam logic [2:0] DIV_COUNT_RESET    = 3'h0;

    // ----------------------------------------------------------------------
    // loader states
    // ----------------------------------------------------------------------
    typedef enum logic [0:0] {
        SCBC_SAMPLE = 1'b0,
        SCBC_HOLD   = 1'b1
    } scbc_state_t;

    // ----------------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------------
    localparam logic       CFG_RESET          = 1'h0;
    localparam logic [1:0] DIV_SEL_RESET      = 2'h0;

    // ratio code to terminal count of the divider
    function automatic logic [2:0] scbc_div_count(input logic [1:0] sel);
        case (sel)
            SCBC_DIV_2: scbc_div_count = DIV_COUNT_2;
            SCBC_DIV_3: scbc_div_count = DIV_COUNT_3;
            SCBC_DIV_4: scbc_div_count = DIV_COUNT_4;
            default:    scbc_div_count = DIV_COUNT_2;
        endcase
    endfunction : scbc_div_count

endpackage : scbc_pkg

/* File: rtl/scbc_clkdiv.sv */
/*
 * Clock enable divider: emits a one-cycle pulse every N host clocks,
 * N being two, three or four.
 * Assumes the ratio select changes at most once outside reset, on the second edge after release.
 */
`timescale 1ns/1ns
module scbc_clkdiv (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [1:0] ratio_sel,
    output logic            tick
);
    import scbc_pkg::*;

    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic       tick_reg;
    logic       tick_next;
    logic [2:0] terminal;

    always_comb begin
        terminal   = scbc_div_count(ratio_sel);
        tick_next  = 1'b0;
        count_next = count_reg + 3'h1;
        if (count_reg >= terminal - 3'h1) begin
            count_next = DIV_COUNT_RESET;
            tick_next  = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= DIV_COUNT_RESET;
            tick_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg  <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : scbc_clkdiv

/* File: tb/scbc_strap_model.sv */
/*
 * Board strap model: pull-up and pull-down resistors that present the
 * configuration straps to the loader.
 * Assumes the bench picks the fitted resistors through strap_set.
 */
`timescale 1ns/1ns
module scbc_strap_model (
    input  wire logic [5:0] strap_set,
    output logic            mem_host_sync_strap,
    output logic            core_ratio_strap,
    output logic            bus_select_strap,
    output logic [1:0]      pci_ratio_strap,
    output logic            isa_src_strap
);
    // --------------------------------------------------------------------
    // resistor levels
    // --------------------------------------------------------------------
    // resistors are never released, so every strap always shows a firm level
    assign mem_host_sync_strap = strap_set[5];
    assign core_ratio_strap    = strap_set[4];
    assign bus_select_strap    = strap_set[3];
    assign pci_ratio_strap     = strap_set[2:1];
    assign isa_src_strap       = strap_set[0];
endmodule : scbc_strap_model

/* File: tb/strap_clock_bus_config_tb.sv */
/*
 * Self-checking bench for the strap loader: loads strap sets under reset,
 * checks the latched configuration and the pci clock enable period.
 * Assumes the loader answers on the second edge after reset release.
 */
`timescale 1ns/1ns
module strap_clock_bus_config_tb;
    import scbc_pkg::*;
    logic       clock;
    logic       rst;
    logic [5:0] strap_set;
    logic       s_mem, s_core, s_bus, s_isa;
    logic [1:0] s_pci;
    logic       mem_sync, core_ratio_double, core_ratio_single, bus_local;
    logic       dma_enable, dma_mux_enable, pci_clk_tick, isa_clk_from_pci, cfg_valid;
    logic [1:0] pci_ratio_sel;
    int         failures;
    int         n_compared;

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    scbc_strap_model u_scbc_strap_model (.strap_set(strap_set), .mem_host_sync_strap(s_mem),
        .core_ratio_strap(s_core), .bus_select_strap(s_bus), .pci_ratio_strap(s_pci), .isa_src_strap(s_isa));

    scbc_loader u_scbc_loader (.clock(clock), .rst(rst), .mem_host_sync_strap(s_mem),
        .core_ratio_strap(s_core), .bus_select_strap(s_bus), .pci_ratio_strap(s_pci),
        .isa_src_strap(s_isa), .mem_sync(mem_sync), .core_ratio_double(core_ratio_double),
        .core_ratio_single(core_ratio_single), .bus_local(bus_local), .dma_enable(dma_enable),
        .dma_mux_enable(dma_mux_enable), .pci_ratio_sel(pci_ratio_sel), .pci_clk_tick(pci_clk_tick),
        .isa_clk_from_pci(isa_clk_from_pci), .cfg_valid(cfg_valid));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // --------------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------------
    task automatic check_defaults;
        check({3'h0, cfg_valid, mem_sync, core_ratio_double, bus_local, isa_clk_from_pci}, 8'h00);
        check({5'h00, dma_enable, dma_mux_enable, core_ratio_single}, 8'h01);
    endtask : check_defaults

    task automatic check_outputs(input logic [5:0] s);
        check({7'h00, cfg_valid}, 8'h01);
        check({7'h00, mem_sync}, {7'h00, s[5]});
        check({6'h00, core_ratio_double, core_ratio_single}, {6'h00, s[4], ~s[4]});
        check({7'h00, bus_local}, {7'h00, s[3]});
        check({6'h00, dma_enable, dma_mux_enable}, {6'h00, ~s[3], ~s[3]});
        check({6'h00, pci_ratio_sel}, {6'h00, (s[2:1] == 2'h3) ? 2'h0 : s[2:1]});
        check({7'h00, isa_clk_from_pci}, {7'h00, s[0]});
    endtask : check_outputs

    // straps held under reset, then one edge with outputs still at default
    task automatic load_straps(input logic [5:0] s);
        @(negedge clock);
        rst       = 1'b1;
        strap_set = s;
        repeat (3) @(negedge clock);
        check_defaults();
        rst = 1'b0;
        @(negedge clock);
        check({7'h00, cfg_valid}, 8'h00);
        @(negedge clock);
        check_outputs(s);
    endtask : load_straps

    task automatic check_period(input logic [7:0] exp);
        int n;
        int w;
        repeat (8) @(negedge clock);
        w = 0;
        while (pci_clk_tick !== 1'b1 && w < 20) begin
            @(negedge clock);
            w++;
        end
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (pci_clk_tick !== 1'b1 && n < 20);
        if (w >= 20 || pci_clk_tick !== 1'b1) begin
            failures++;
            complete_run();
        end else begin
            check(8'(n), exp);
        end
    endtask : check_period

    // strap moves after release must not reach the configuration
    task automatic check_hold(input logic [5:0] s);
        strap_set = ~s;
        repeat (10) @(negedge clock);
        check_outputs(s);
    endtask : check_hold

    logic [5:0] cfg_tab [5] = '{6'h00, 6'h3F, 6'h2A, 6'h15, 6'h24};
    logic [7:0] per_tab [4] = '{8'h02, 8'h03, 8'h04, 8'h02};

    initial begin
        rst        = 1'b1;
        strap_set  = 6'h00;
        failures   = 0;
        n_compared = 0;
        repeat (8) @(negedge clock);
        check_defaults();
        foreach (cfg_tab[i]) begin
            load_straps(cfg_tab[i]);
            check_period(per_tab[cfg_tab[i][2:1]]);
        end
        check_hold(6'h24);
        load_straps(6'h3F);
        check_hold(6'h3F);
        complete_run();
    end
endmodule : strap_clock_bus_config_tb
